// ===== inc/ccrc_defs.svh
// Constants of the cluster clock and reset control block.
// Assumes inclusion by bare name from the package and the testbench files.
`ifndef CCRC_DEFS_SVH
`define CCRC_DEFS_SVH

// ============================================================
// Build options
`define CCRC_NUM_CORES        4
`define CCRC_HAS_CLK_STOP     1'b0
`define CCRC_L2_INIT_LINES    9'h100
`define CCRC_L2_INDEX_W       8

// ============================================================
// Register byte offsets
`define CCRC_OFF_CTRL         8'h00
`define CCRC_OFF_CORE_STOP    8'h04
`define CCRC_OFF_PORST        8'h08
`define CCRC_OFF_CORERST      8'h0C
`define CCRC_OFF_FPRST        8'h10
`define CCRC_OFF_DBGRST       8'h14
`define CCRC_OFF_STATUS       8'h18

// ============================================================
// Control register fields
`define CCRC_CTRL_GATE_BIT    0
`define CCRC_CTRL_L2RST_BIT   1
`define CCRC_CTRL_SKIP_BIT    2

// ============================================================
// Status register fields
`define CCRC_ST_CORE_LSB      0
`define CCRC_ST_FP_LSB        4
`define CCRC_ST_DBG_LSB       8
`define CCRC_ST_L2RST_BIT     12
`define CCRC_ST_BUSY_BIT      13
`define CCRC_ST_DONE_BIT      14
`define CCRC_ST_CLUSTER_CLOCK_GATE_LSB     16
`define CCRC_ST_L2CLK_BIT     20

// ============================================================
// Reset values
`define CCRC_RST_GATE         1'b1
`define CCRC_RST_L2RST_N      1'b0
`define CCRC_RST_SKIP         1'b0
`define CCRC_RST_CORE_VEC     4'h0
`define CCRC_RST_STOP_VEC     4'h0

`endif

// ===== inc/ccrc_pkg.sv
// Types shared by the cluster clock and reset control files.
// Assumes the constants header is on the include path.
`include "ccrc_defs.svh"

package ccrc_pkg;

  // ============================================================
  // Per-core reset requests or domain resets, all active low
  typedef struct packed {
    logic poweron_n;
    logic core_n;
    logic fp_n;
    logic dbg_n;
  } ccrc_core_rst_t;

  // ============================================================
  // Shared cache initialisation walk
  typedef enum logic [2:0] {
    CCRC_INIT_IDLE = 3'b001,
    CCRC_INIT_WALK = 3'b010,
    CCRC_INIT_DONE = 3'b100
  } ccrc_init_state_t;

endpackage

// ===== rtl/ccrc_rst_sync.sv
// Reset synchroniser: asserts at once, releases after two clock edges.
// Assumes rst_in_n comes straight from a flip-flop or a pin, glitch free.
module ccrc_rst_sync (
  // Clock and resets
  input  wire logic clk,
  input  wire logic rst_in_n,
  // Synchronised reset
  output logic      rst_out_n
);
  import ccrc_pkg::*;

  logic stage1;

  // ============================================================
  // Two stages; the first feeds only the second
  always_ff @(posedge clk or negedge rst_in_n) begin
    if (!rst_in_n) begin
      stage1    <= 1'b0;
      rst_out_n <= 1'b0;
    end else begin
      stage1    <= 1'b1;
      rst_out_n <= stage1;
    end
  end

endmodule // ccrc_rst_sync

// ===== rtl/ccrc_core_dom.sv
// One core's reset domains built from its four reset requests.
// Assumes requests are flip-flop outputs in the clk domain.
module ccrc_core_dom (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    presetn,
  // Requested resets
  input  wire ccrc_pkg::ccrc_core_rst_t req,
  // Domain resets, synchronised release
  output ccrc_pkg::ccrc_core_rst_t     dom
);
  import ccrc_pkg::*;

  logic core_in_n;
  logic fp_in_n;
  logic dbg_in_n;

  // ============================================================
  // Power-on reset reaches every domain of the core
  assign core_in_n = presetn & req.poweron_n & req.core_n;
  assign fp_in_n   = presetn & req.poweron_n & req.core_n & req.fp_n;
  assign dbg_in_n  = presetn & req.poweron_n & req.dbg_n;
  assign dom.poweron_n = dom.core_n & dom.dbg_n;

  // Release of each domain waits for the clock
  ccrc_rst_sync u_core (.clk(clk), .rst_in_n(core_in_n), .rst_out_n(dom.core_n));
  ccrc_rst_sync u_fp   (.clk(clk), .rst_in_n(fp_in_n),   .rst_out_n(dom.fp_n));
  ccrc_rst_sync u_dbg  (.clk(clk), .rst_in_n(dbg_in_n),  .rst_out_n(dom.dbg_n));

endmodule // ccrc_core_dom

// ===== rtl/ccrc_top.sv
// Cluster clock and reset control: APB registers, clock enables, reset domains.
// Assumes one clock pclk and an APB master that keeps the protocol.
// Assumes the cache array clears the line at l2_init_index while l2_init_busy is high.
//
// The register addresses and register access over APB were chosen for this implementation.
module ccrc_top (
  // APB clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // APB slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Clock enables
  output logic      [`CCRC_NUM_CORES-1:0]         core_clk_en,
  output logic                                    l2_clk_en,
  // Reset domains, active low
  output logic      [`CCRC_NUM_CORES-1:0]         core_logic_rst_n,
  output logic      [`CCRC_NUM_CORES-1:0]         fp_simd_rst_n,
  output logic      [`CCRC_NUM_CORES-1:0]         dbg_trace_rst_n,
  output logic                                    shared_cache_rst_n,
  // Shared cache initialisation walk
  output logic                                    l2_init_busy,
  output logic      [`CCRC_L2_INDEX_W-1:0]        l2_init_index
);
  import ccrc_pkg::*;

  localparam int NC = `CCRC_NUM_CORES;

  // ============================================================
  // Register state
  logic          cluster_clock_gate;
  logic          l2_rst_req_n;
  logic          shared_cache_init_skip;
  logic [NC-1:0] core_clock_stop;
  // Request vectors, active low, one bit per core
  logic [NC-1:0] core_poweron_rst_n;
  logic [NC-1:0] core_logic_req_n;
  logic [NC-1:0] fp_simd_req_n;
  logic [NC-1:0] dbg_trace_req_n;

  // APB phase qualifiers
  logic          setup_phase;
  logic          wr_commit;
  logic          next_hit;
  logic [31:0]   next_rdata;
  logic [31:0]   status_word;

  // Domain results
  ccrc_core_rst_t          core_req [NC];
  ccrc_core_rst_t          core_dom [NC];
  logic [NC-1:0]           dom_core_n;
  logic [NC-1:0]           dom_fp_n;
  logic [NC-1:0]           dom_dbg_n;
  logic                    l2_in_n;
  logic                    l2_sync_n;
  logic                    l2_sync_d;
  // Walk state and line counter
  ccrc_init_state_t        init_state;
  logic [8:0]              init_count;
  logic                    init_done;

  // ============================================================
  // Address decode, reused by read and write paths
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] off);
    addr_is = (addr == off);
  endfunction

  // Access is taken on the first access cycle; pready only pulses then
  assign setup_phase = psel & ~penable;
  assign wr_commit   = psel & penable & pready & pwrite;

  // ============================================================
  // APB handshake; one wait-free access cycle after setup
  // Back-to-back setups are fine: pready is rebuilt from every setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  // Read data and error captured at setup, held through access
  // Unmapped offsets raise pslverr; a write there changes no state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= ~next_hit;
    // Back to zero once the access cycle is over
    end else if (pready) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ============================================================
  // Status word shows the block's own state
  // Read-only; a write to this offset is taken without error and dropped
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CCRC_ST_CORE_LSB +: NC]  = dom_core_n;
    status_word[`CCRC_ST_FP_LSB +: NC]    = dom_fp_n;
    status_word[`CCRC_ST_DBG_LSB +: NC]   = dom_dbg_n;
    status_word[`CCRC_ST_L2RST_BIT]       = shared_cache_rst_n;
    status_word[`CCRC_ST_BUSY_BIT]        = l2_init_busy;
    status_word[`CCRC_ST_DONE_BIT]        = init_done;
    status_word[`CCRC_ST_CLUSTER_CLOCK_GATE_LSB +: NC] = core_clk_en;
    status_word[`CCRC_ST_L2CLK_BIT]       = l2_clk_en;
  end

  // Read mux; unmapped addresses read zero and flag an error
  // One offset per register, all word aligned
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_hit   = 1'b1;
    if (addr_is(paddr, `CCRC_OFF_CTRL)) begin
      next_rdata[`CCRC_CTRL_GATE_BIT]  = cluster_clock_gate;
      next_rdata[`CCRC_CTRL_L2RST_BIT] = l2_rst_req_n;
      next_rdata[`CCRC_CTRL_SKIP_BIT]  = shared_cache_init_skip;
    end else if (addr_is(paddr, `CCRC_OFF_CORE_STOP)) begin
      next_rdata[NC-1:0] = core_clock_stop;
    end else if (addr_is(paddr, `CCRC_OFF_PORST)) begin
      next_rdata[NC-1:0] = core_poweron_rst_n;
    end else if (addr_is(paddr, `CCRC_OFF_CORERST)) begin
      next_rdata[NC-1:0] = core_logic_req_n;
    end else if (addr_is(paddr, `CCRC_OFF_FPRST)) begin
      next_rdata[NC-1:0] = fp_simd_req_n;
    end else if (addr_is(paddr, `CCRC_OFF_DBGRST)) begin
      next_rdata[NC-1:0] = dbg_trace_req_n;
    end else if (addr_is(paddr, `CCRC_OFF_STATUS)) begin
      next_rdata = status_word;
    end else begin
      next_hit = 1'b0;
    end
  end

  // ============================================================
  // Cluster control register
  // Software must only drop the gate with every core idle and both ports quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cluster_clock_gate     <= `CCRC_RST_GATE;
      l2_rst_req_n           <= `CCRC_RST_L2RST_N;
      shared_cache_init_skip <= `CCRC_RST_SKIP;
    end else if (wr_commit && addr_is(paddr, `CCRC_OFF_CTRL)) begin
      cluster_clock_gate     <= pwdata[`CCRC_CTRL_GATE_BIT];
      l2_rst_req_n           <= pwdata[`CCRC_CTRL_L2RST_BIT];
      shared_cache_init_skip <= pwdata[`CCRC_CTRL_SKIP_BIT];
    end
  end

  // Clock stop bits; without the build option they stay at zero
  // Limitation: writes are accepted but leave the bits at zero in this build
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clock_stop <= `CCRC_RST_STOP_VEC;
    end else if (wr_commit && addr_is(paddr, `CCRC_OFF_CORE_STOP)) begin
      core_clock_stop <= pwdata[NC-1:0] & {NC{`CCRC_HAS_CLK_STOP}};
    end
  end

  // Per-core reset request vectors, one bit per core, all held in reset at start
  // Each offset owns one vector; bits above the core count are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_poweron_rst_n <= `CCRC_RST_CORE_VEC;
      core_logic_req_n   <= `CCRC_RST_CORE_VEC;
      fp_simd_req_n      <= `CCRC_RST_CORE_VEC;
      dbg_trace_req_n    <= `CCRC_RST_CORE_VEC;
    end else if (wr_commit) begin
      if (addr_is(paddr, `CCRC_OFF_PORST)) begin
        core_poweron_rst_n <= pwdata[NC-1:0];
      end
      if (addr_is(paddr, `CCRC_OFF_CORERST)) begin
        core_logic_req_n <= pwdata[NC-1:0];
      end
      if (addr_is(paddr, `CCRC_OFF_FPRST)) begin
        fp_simd_req_n <= pwdata[NC-1:0];
      end
      if (addr_is(paddr, `CCRC_OFF_DBGRST)) begin
        dbg_trace_req_n <= pwdata[NC-1:0];
      end
    end
  end

  // ============================================================
  // Clock enables; registered so the gate cell sees a clean level
  // Stop bits mask single cores; the shared cache clock follows the gate only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_clk_en <= {NC{1'b0}};
      l2_clk_en   <= 1'b0;
    end else begin
      core_clk_en <= {NC{cluster_clock_gate}} & ~core_clock_stop;
      l2_clk_en   <= cluster_clock_gate;
    end
  end

  // ============================================================
  // Per-core reset domains
  generate
    for (genvar i = 0; i < NC; i++) begin : g_core
      // Gather this core's four requests into the carrier
      assign core_req[i].poweron_n = core_poweron_rst_n[i];
      assign core_req[i].core_n    = core_logic_req_n[i];
      assign core_req[i].fp_n      = fp_simd_req_n[i];
      assign core_req[i].dbg_n     = dbg_trace_req_n[i];

      ccrc_core_dom u_dom (
        .clk     (pclk),
        .presetn (presetn),
        .req     (core_req[i]),
        .dom     (core_dom[i])
      );

      // Split the domains back into per-domain vectors
      assign dom_core_n[i] = core_dom[i].core_n;
      assign dom_fp_n[i]   = core_dom[i].fp_n;
      assign dom_dbg_n[i]  = core_dom[i].dbg_n;
    end
  endgenerate

  // Synchroniser outputs are flops; this just names them as ports
  // No logic between synchroniser and pin, so no glitch can reach a core
  assign core_logic_rst_n = dom_core_n;
  assign fp_simd_rst_n    = dom_fp_n;
  assign dbg_trace_rst_n  = dom_dbg_n;

  // ============================================================
  // Shared cache controller reset
  // Asserts with no clock through the synchroniser; release waits two edges
  assign l2_in_n = presetn & l2_rst_req_n;

  ccrc_rst_sync u_l2_sync (
    .clk       (pclk),
    .rst_in_n  (l2_in_n),
    .rst_out_n (l2_sync_n)
  );

  // Controller leaves reset only once the walk is over or skipped; waiting for
  // the done state avoids a one-cycle release before the walk starts
  always_ff @(posedge pclk or negedge l2_sync_n) begin
    if (!l2_sync_n) begin
      shared_cache_rst_n <= 1'b0;
    end else begin
      shared_cache_rst_n <= (init_state == CCRC_INIT_DONE);
    end
  end

  // Release edge of the synchronised request starts the walk
  // Only the synchroniser output is delayed here, never its first stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l2_sync_d <= 1'b0;
    end else begin
      l2_sync_d <= l2_sync_n;
    end
  end

  // ============================================================
  // Contents walk: one line per cycle, skipped when the skip bit is set
  // Skip bit is read once, at the release edge; later writes wait for the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_state <= CCRC_INIT_IDLE;
      init_count <= 9'h000;
      init_done  <= 1'b0;
    end else if (!l2_sync_n) begin
      init_state <= CCRC_INIT_IDLE;
      init_count <= 9'h000;
      init_done  <= 1'b0;
    end else begin
      case (init_state)
        CCRC_INIT_IDLE: begin
          // Wait for the release edge of the request
          if (!l2_sync_d) begin
            if (shared_cache_init_skip) begin
              init_state <= CCRC_INIT_DONE;
            end else begin
              init_state <= CCRC_INIT_WALK;
              init_count <= 9'h000;
            end
          end
        end
        CCRC_INIT_WALK: begin
          // Last line this cycle; the controller may leave reset next
          if (init_count == `CCRC_L2_INIT_LINES - 9'h001) begin
            init_state <= CCRC_INIT_DONE;
            init_done  <= 1'b1;
          end else begin
            init_count <= init_count + 9'h001;
          end
        end
        CCRC_INIT_DONE: begin
          // Stay until the request is taken away
          init_state <= CCRC_INIT_DONE;
        end
        default: begin
          // Unused code: start over from idle
          init_state <= CCRC_INIT_IDLE;
        end
      endcase
    end
  end

  // Walk outputs registered for the cache array
  // Index lags the counter by one cycle, in step with l2_init_busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      l2_init_busy  <= 1'b0;
      l2_init_index <= {`CCRC_L2_INDEX_W{1'b0}};
    end else begin
      l2_init_busy  <= (init_state == CCRC_INIT_WALK);
      l2_init_index <= init_count[`CCRC_L2_INDEX_W-1:0];
    end
  end

endmodule // ccrc_top

// ===== tb/ccrc_top_props.sv
// Port checker for the cluster clock and reset control block.
// Assumes it is bound to ccrc_top and sees only that module's ports.
`include "ccrc_defs.svh"
module ccrc_top_props (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Clock enables and resets
  input wire logic [3:0]  core_clk_en,
  input wire logic        l2_clk_en,
  input wire logic [3:0]  core_logic_rst_n,
  input wire logic [3:0]  fp_simd_rst_n,
  input wire logic [3:0]  dbg_trace_rst_n,
  input wire logic        shared_cache_rst_n,
  input wire logic        l2_init_busy,
  input wire logic [7:0]  l2_init_index
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Write commit strobe
  wire logic cmt = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================
  // Bus answer
  ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ready_single_a: assert property (pready |=> !pready) else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  // ====================
  // Clock enables; no stop bits in this build
  clk_gate_all_a: assert property (core_clk_en == {4{l2_clk_en}})
    else $error("core clock enable differs from gate");
  gate_follows_a: assert property (cmt && paddr == 8'h00 |-> ##2 l2_clk_en == $past(pwdata[0], 2))
    else $error("gate not applied");
  // ====================
  // Reset domains: assertion at the commit edge
  porst_all_a: assert property (cmt && paddr == 8'h08 |=>
    ((core_logic_rst_n | fp_simd_rst_n | dbg_trace_rst_n) & ~$past(pwdata[3:0])) == 4'h0) else $error("porst");
  corerst_a: assert property (cmt && paddr == 8'h0C |=>
    ((core_logic_rst_n | fp_simd_rst_n) & ~$past(pwdata[3:0])) == 4'h0) else $error("core reset");
  fprst_a: assert property (cmt && paddr == 8'h10 |=> (fp_simd_rst_n & ~$past(pwdata[3:0])) == 4'h0)
    else $error("fp reset");
  dbgrst_a: assert property (cmt && paddr == 8'h14 |=> (dbg_trace_rst_n & ~$past(pwdata[3:0])) == 4'h0)
    else $error("dbg reset");
  fp_in_core_a: assert property ((fp_simd_rst_n & ~core_logic_rst_n) == 4'h0)
    else $error("fp out of reset before core");
  // Release only through the two-flop chain
  release_synced_a: assert property ($rose(core_logic_rst_n[0]) |-> $past(cmt, 2) || $past(cmt, 3))
    else $error("unsynchronised release");
  // ====================
  // Shared cache
  walk_holds_rst_a: assert property (l2_init_busy |-> !shared_cache_rst_n)
    else $error("cache controller free during walk");
  index_steps_a: assert property (l2_init_busy |-> ($rose(l2_init_busy) ? l2_init_index == 8'h00
    : l2_init_index == $past(l2_init_index) + 8'h01)) else $error("walk index out of step");
  l2_assert_a: assert property (cmt && paddr == 8'h00 && !pwdata[1] |=> !shared_cache_rst_n)
    else $error("cache reset not applied");
  cover property (cmt && paddr == 8'h00);
  cover property (pslverr);
  cover property ($fell(l2_init_busy));
endmodule // ccrc_top_props

bind ccrc_top ccrc_top_props ccrc_top_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_clk_en(core_clk_en), .l2_clk_en(l2_clk_en), .core_logic_rst_n(core_logic_rst_n),
  .fp_simd_rst_n(fp_simd_rst_n), .dbg_trace_rst_n(dbg_trace_rst_n), .shared_cache_rst_n(shared_cache_rst_n),
  .l2_init_busy(l2_init_busy), .l2_init_index(l2_init_index));

// ===== tb/ccrc_ctrl_model.sv
// Controller model: the APB master of the clock, reset and power controller.
// Assumes a slave that answers with pready; a bounded wait guards a hang.
module ccrc_ctrl_model (
  // Clock
  input  wire logic        pclk,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // Answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // ====================
  // One transfer; ready, data and error all taken at the same rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      ok = (pready === 1'b1);
    end while (!ok && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines carry junk so a slave cannot lean on them
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // ccrc_ctrl_model

// ===== tb/cluster_clock_reset_control_bench.sv
// Self-checking bench of the cluster clock and reset control block.
// Assumes the controller model as APB master and a 50 MHz pclk.
`include "ccrc_defs.svh"
module cluster_clock_reset_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        l2_clk_en, shared_cache_rst_n, l2_init_busy;
  logic [7:0]  paddr, l2_init_index;
  logic [31:0] pwdata, prdata;
  logic [3:0]  core_clk_en, core_logic_rst_n, fp_simd_rst_n, dbg_trace_rst_n;
  int          n_errors = 0;
  int          check_count = 0;
  ccrc_ctrl_model ccrc_ctrl_model_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ccrc_top ccrc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_clk_en(core_clk_en), .l2_clk_en(l2_clk_en), .core_logic_rst_n(core_logic_rst_n),
    .fp_simd_rst_n(fp_simd_rst_n), .dbg_trace_rst_n(dbg_trace_rst_n), .shared_cache_rst_n(shared_cache_rst_n),
    .l2_init_busy(l2_init_busy), .l2_init_index(l2_init_index));
  // ====================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp, input logic e);
    logic [31:0] r;
    logic        err, ok;
    ccrc_ctrl_model_i.xfer(w, a, d, r, err, ok);
    if (!ok) begin
      n_errors++;
      report_and_stop();
    end
    check(err, e);
    if (!w) check(r, exp);
  endtask
  // Let n edges pass, then look at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // ====================
  // Scenarios
  task automatic t_reset_vals();
    apb(0, `CCRC_OFF_CTRL, 0, 32'h1, 0);
    for (int a = 4; a <= 20; a += 4) apb(0, a, 0, 32'h0, 0);
    apb(0, `CCRC_OFF_STATUS, 0, 32'h001F_0000, 0);
  endtask
  task automatic t_refused();
    apb(0, 8'h1C, 0, 32'h0, 1);
    apb(1, 8'h40, 32'hFFFF_FFFF, 0, 1);
    apb(1, `CCRC_OFF_STATUS, 32'hFFFF_FFFF, 0, 0);
    apb(0, `CCRC_OFF_STATUS, 0, 32'h001F_0000, 0);
  endtask
  task automatic t_stop();
    // Cores are still in power-on reset, so a stop request is legal
    apb(1, `CCRC_OFF_CORE_STOP, 32'hF, 0, 0);
    settle(2);
    check(core_clk_en, 4'hF);
    apb(0, `CCRC_OFF_CORE_STOP, 0, 32'h0, 0);
    apb(1, `CCRC_OFF_CORE_STOP, 32'h0, 0, 0);
  endtask
  task automatic t_gate();
    // All cores held in reset, hence idle, before the gate drops
    apb(1, `CCRC_OFF_CTRL, 32'h0, 0, 0);
    settle(2);
    check({l2_clk_en, core_clk_en}, 5'h00);
    apb(1, `CCRC_OFF_CTRL, 32'h1, 0, 0);
    settle(2);
    check({l2_clk_en, core_clk_en}, 5'h1F);
  endtask
  task automatic t_l2();
    int busy, n;
    busy = 0;
    apb(1, `CCRC_OFF_CTRL, 32'h7, 0, 0);
    for (n = 0; n < 20 && shared_cache_rst_n !== 1'b1; n++) begin
      @(negedge pclk);
      busy += (l2_init_busy === 1'b1);
    end
    if (shared_cache_rst_n !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    check({busy[7:0], shared_cache_rst_n}, 9'h001);
    apb(1, `CCRC_OFF_CTRL, 32'h1, 0, 0);
    settle(0);
    check(shared_cache_rst_n, 1'b0);
    apb(1, `CCRC_OFF_CTRL, 32'h3, 0, 0);
    for (n = 0; n < 600 && shared_cache_rst_n !== 1'b1; n++) begin
      @(negedge pclk);
      busy += (l2_init_busy === 1'b1);
    end
    if (shared_cache_rst_n !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    check(busy, `CCRC_L2_INIT_LINES);
    apb(0, `CCRC_OFF_STATUS, 0, 32'h001F_5000, 0);
  endtask
  task automatic t_domains();
    logic [7:0]  off [4] = '{8'h10, 8'h14, 8'h0C, 8'h08};
    logic [11:0] exp [4] = '{12'hFEF, 12'hDFF, 12'hFBB, 12'h777};
    for (int a = 8; a <= 20; a += 4) apb(1, a, 32'hF, 0, 0);
    settle(0);
    check(dbg_trace_rst_n, 4'h0);
    settle(3);
    check({dbg_trace_rst_n, fp_simd_rst_n, core_logic_rst_n}, 12'hFFF);
    for (int i = 0; i < 4; i++) begin
      apb(1, off[i], {28'h0, exp[i][11:8] & exp[i][7:4] & exp[i][3:0]}, 0, 0);
      settle(1);
      check({dbg_trace_rst_n, fp_simd_rst_n, core_logic_rst_n}, exp[i]);
      apb(1, off[i], 32'hF, 0, 0);
      settle(3);
      check({dbg_trace_rst_n, fp_simd_rst_n, core_logic_rst_n}, 12'hFFF);
    end
  endtask
  // ====================
  // Clock, reset, sequence and watchdog
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_refused();
    t_stop();
    t_gate();
    t_l2();
    t_domains();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end
endmodule // cluster_clock_reset_control_bench
